// file: rtl/stpfp_top.sv
// stepper driver control: enable gating, excitation hold, trip latches, fault flag, registers
// assumes all pins synchronous to clk; nrst is the power-on reset from the supply monitor
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`default_nettype none

module stpfp_top
(
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic                          sys_reset_low,
    input  wire logic                          enable_in,
    input  wire logic                          phase_a_in_n,
    input  wire logic                          phase_a_bar_in_n,
    input  wire logic                          phase_b_in_n,
    input  wire logic                          phase_b_bar_in_n,
    input  wire logic                          pwm_on,
    input  wire logic                          cur_over_limit,
    input  wire logic                          temp_over_limit,
    output logic                               drv_a,
    output logic                               drv_a_bar,
    output logic                               drv_b,
    output logic                               drv_b_bar,
    output logic                               fault_o,
    output logic                               fault_oe,
    input  wire logic [stpfp_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [stpfp_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [stpfp_pkg::DATA_W-1:0]  reg_rdata,
    output logic                               irq
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // simultaneous on prevention for one pair, {bar, true}
    function automatic logic [1:0] pair_lock(input logic [1:0] req);
        pair_lock = (req == 2'h3) ? 2'h0 : req;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    stpfp_pkg::stpfp_state_t       state_ff;
    stpfp_pkg::stpfp_state_t       nxt_state;

    logic [3:0]                    phase_ff;
    logic [3:0]                    nxt_phase;
    logic                          oc_latch_ff;
    logic                          ot_latch_ff;
    logic                          allow_ff;
    logic [3:0]                    drv_ff;
    logic                          fault_ff;
    logic [stpfp_pkg::DATA_W-1:0]  rdata_ff;
    logic [stpfp_pkg::DATA_W-1:0]  nxt_rdata;

    wire                           int_rst;
    wire                           run;
    wire                           tripped;
    wire                           oc_trip;
    wire                           ot_trip;
    wire  [3:0]                    phase_req;
    wire  [3:0]                    phase_safe;
    wire  [3:0]                    nxt_drv;
    wire                           sel_ctrl;
    wire                           sel_status;
    wire                           sel_irq_stat;
    wire                           sel_irq_mask;
    wire  [stpfp_pkg::IRQ_W-1:0]   irq_stat;
    wire  [stpfp_pkg::IRQ_W-1:0]   irq_mask;
    wire  [stpfp_pkg::IRQ_W-1:0]   irq_evt;
    wire  [stpfp_pkg::DATA_W-1:0]  status_word;

    ////////////////////////////////////////////////////////////////////////////
    // reset and clock halt

    // power-on reset acts through nrst, the pin through a synchronous clear
    assign int_rst = ~sys_reset_low; // RULE_07 RULE_11 RULE_14
    assign run     = enable_in & ~int_rst; // RULE_03
    assign tripped = oc_latch_ff | ot_latch_ff;

    ////////////////////////////////////////////////////////////////////////////
    // phase inputs, active low, pairwise interlock

    assign phase_req  = ~{phase_b_bar_in_n, phase_b_in_n, phase_a_bar_in_n, phase_a_in_n}; // RULE_16
    assign phase_safe = {pair_lock(phase_req[3:2]), pair_lock(phase_req[1:0])}; // RULE_16

    ////////////////////////////////////////////////////////////////////////////
    // protection detectors

    stpfp_blank u_blank
    (
        .clk      (clk),
        .nrst     (nrst),
        .clr      (int_rst),
        .run      (run),
        .pwm_on   (pwm_on),
        .over_cur (cur_over_limit),
        .trip     (oc_trip)
    );

    assign ot_trip = run & temp_over_limit; // RULE_10

    ////////////////////////////////////////////////////////////////////////////
    // state machine

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            stpfp_pkg::ST_RESET:
            begin
                if (!int_rst)
                begin
                    nxt_state = (tripped || oc_trip || ot_trip) ? stpfp_pkg::ST_TRIP // RULE_05
                              : enable_in ? stpfp_pkg::ST_RUN : stpfp_pkg::ST_HOLD;
                end
            end
            stpfp_pkg::ST_RUN:
            begin
                if (int_rst)
                begin
                    nxt_state = stpfp_pkg::ST_RESET;
                end
                else if (oc_trip || ot_trip)
                begin
                    nxt_state = stpfp_pkg::ST_TRIP; // RULE_05
                end
                else if (!enable_in)
                begin
                    nxt_state = stpfp_pkg::ST_HOLD; // RULE_02
                end
            end
            stpfp_pkg::ST_HOLD:
            begin
                if (int_rst)
                begin
                    nxt_state = stpfp_pkg::ST_RESET;
                end
                else if (oc_trip || ot_trip)
                begin
                    nxt_state = stpfp_pkg::ST_TRIP; // RULE_05
                end
                else if (enable_in)
                begin
                    nxt_state = stpfp_pkg::ST_RUN; // RULE_15
                end
            end
            stpfp_pkg::ST_TRIP:
            begin
                if (int_rst)
                begin
                    nxt_state = stpfp_pkg::ST_RESET; // RULE_06
                end
            end
            default:
            begin
                nxt_state = stpfp_pkg::ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= stpfp_pkg::ST_RESET;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // excitation state, held while halted

    assign nxt_phase = int_rst ? stpfp_pkg::PHASE_INIT // RULE_14
                     : run ? phase_safe : phase_ff; // RULE_01 RULE_15

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase_ff <= stpfp_pkg::PHASE_INIT;
        end
        else
        begin
            phase_ff <= nxt_phase;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trip latches

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            oc_latch_ff <= 1'b0;
            ot_latch_ff <= 1'b0;
        end
        else if (int_rst)
        begin
            oc_latch_ff <= 1'b0; // RULE_06
            ot_latch_ff <= 1'b0;
        end
        else
        begin
            oc_latch_ff <= oc_latch_ff | oc_trip; // RULE_05
            ot_latch_ff <= ot_latch_ff | ot_trip; // RULE_05
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // drive outputs and fault flag

    // outputs only in run with the latches clear and software allowing
    assign nxt_drv = (nxt_state == stpfp_pkg::ST_RUN && allow_ff) ? nxt_phase : stpfp_pkg::PHASE_OFF; // RULE_01 RULE_02 RULE_05

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            drv_ff   <= stpfp_pkg::PHASE_OFF;
            fault_ff <= 1'b0;
        end
        else
        begin
            drv_ff   <= nxt_drv;
            fault_ff <= ~int_rst & (tripped | oc_trip | ot_trip); // RULE_04 RULE_17
        end
    end

    assign drv_a     = drv_ff[0];
    assign drv_a_bar = drv_ff[1];
    assign drv_b     = drv_ff[2];
    assign drv_b_bar = drv_ff[3];

    // open drain: only ever drives low
    assign fault_o   = 1'b0;
    assign fault_oe  = fault_ff; // RULE_04 RULE_17

    ////////////////////////////////////////////////////////////////////////////
    // register decode

    assign sel_ctrl     = (reg_addr == stpfp_pkg::OFS_CTRL);
    assign sel_status   = (reg_addr == stpfp_pkg::OFS_STATUS);
    assign sel_irq_stat = (reg_addr == stpfp_pkg::OFS_IRQ_STAT);
    assign sel_irq_mask = (reg_addr == stpfp_pkg::OFS_IRQ_MASK);

    assign status_word = {24'h0, phase_ff, 1'b0, (state_ff == stpfp_pkg::ST_RUN), ot_latch_ff, oc_latch_ff};

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            allow_ff <= stpfp_pkg::CTRL_ALLOW_RST;
        end
        else if (reg_wr && sel_ctrl)
        begin
            allow_ff <= reg_wdata[stpfp_pkg::CTRL_ALLOW_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts

    assign irq_evt = {ot_trip & ~ot_latch_ff, oc_trip & ~oc_latch_ff};

    stpfp_irq u_irq
    (
        .clk     (clk),
        .nrst    (nrst),
        .evt     (irq_evt),
        .stat_wr (reg_wr & sel_irq_stat),
        .mask_wr (reg_wr & sel_irq_mask),
        .wdata   (reg_wdata[stpfp_pkg::IRQ_W-1:0]),
        .stat    (irq_stat),
        .mask    (irq_mask),
        .irq     (irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe, zero otherwise

    always_comb
    begin
        nxt_rdata = '0;
        if (reg_rd)
        begin
            case (1'b1)
                sel_ctrl:     nxt_rdata = {31'h0, allow_ff};
                sel_status:   nxt_rdata = status_word;
                sel_irq_stat: nxt_rdata = {30'h0, irq_stat};
                sel_irq_mask: nxt_rdata = {30'h0, irq_mask};
                default:      nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_ff <= '0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule

`default_nettype wire

// file: rtl/stpfp_pkg.sv
// constants, register map and state type of the stepper enable and fault protection block
// assumes a single 20 MHz clock and synchronous pin inputs
//
// Summary of operation
// RULE_01 - with enable high the phase drive outputs follow the phase inputs.
// RULE_02 - with enable low all four phase drive outputs are off.
// RULE_03 - with enable low the internal clock halts and only the reset input can change internal state; register writes still change the ctrl and irq registers.
// RULE_04 - the open-drain fault flag is pulled low whenever an overcurrent or overheat trip has been caught.
// RULE_05 - each trip sets a latch and a set latch holds all phase drive outputs off.
// RULE_06 - a trip latch clears only on power-on reset or a high-low-high pulse on the reset input.
// RULE_07 - internal reset is the power-on reset or the active-low reset input; tying the input high leaves power-on alone.
// RULE_08 - the overcurrent trip fires when the sensed current is above the 3.5 A threshold.
// RULE_09 - overcurrent is blanked for 5.5 us from the start of each PWM on period.
// RULE_10 - the overheat trip fires at a substrate temperature of 144 C and sets a protection latch.
// RULE_11 - the power-on reset holds the logic initialised until the logic supply reaches 4 V.
// RULE_12 - the controller keeps enable low while the logic supply is under 4.75 V.
// RULE_13 - the controller should slow the phase rate gradually before stopping.
// RULE_14 - the reset input low resets the device and its rising edge sets excitation to phases A and BB.
// RULE_15 - when enable returns high the excitation resumes with the state held before it went low; drive outputs take the current phase inputs instead.
// RULE_16 - phase inputs are active low and A with A-bar, B with B-bar never conduct together.
// RULE_17 - when a reset clears the latches the fault flag returns to released high impedance.
`default_nettype none

package stpfp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned BLANK_NS     = 5500;
    localparam int unsigned BLANK_CYC    = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned BLANK_W      = 8;

    ////////////////////////////////////////////////////////////////////////////
    // register bus
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 32;
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h0c;

    // ctrl fields
    localparam int unsigned CTRL_ALLOW_BIT = 0;
    localparam logic        CTRL_ALLOW_RST = 1'h1;

    // status fields
    localparam int unsigned ST_OC_BIT    = 0;
    localparam int unsigned ST_OT_BIT    = 1;
    localparam int unsigned ST_RUN_BIT   = 2;
    localparam int unsigned ST_PH_LSB    = 4;

    // irq fields
    localparam int unsigned IRQ_W        = 2;
    localparam int unsigned IRQ_OC_BIT   = 0;
    localparam int unsigned IRQ_OT_BIT   = 1;
    localparam logic [1:0]  IRQ_MASK_RST = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // excitation, order {b_bar, b, a_bar, a}
    localparam logic [3:0]  PHASE_INIT   = 4'h9;
    localparam logic [3:0]  PHASE_OFF    = 4'h0;

    typedef enum logic [3:0]
    {
        ST_RESET = 4'b0001,
        ST_RUN   = 4'b0010,
        ST_HOLD  = 4'b0100,
        ST_TRIP  = 4'b1000
    } stpfp_state_t;

endpackage

`default_nettype wire

// file: rtl/stpfp_blank.sv
// overcurrent blanking timer and trip detector
// assumes synchronous inputs and a run enable that stands for the halted clock
`default_nettype none

module stpfp_blank
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic clr,
    input  wire logic run,
    input  wire logic pwm_on,
    input  wire logic over_cur,
    output logic      trip
);

    logic [stpfp_pkg::BLANK_W-1:0] cnt_ff;
    logic [stpfp_pkg::BLANK_W-1:0] nxt_cnt;
    logic                          pwm_on_ff;
    wire                           on_start;
    wire                           blanked;

    ////////////////////////////////////////////////////////////////////////////
    // blanking window from each on period start
    assign on_start = pwm_on & ~pwm_on_ff;
    assign blanked  = on_start | (cnt_ff != '0);
    assign nxt_cnt  = on_start ? stpfp_pkg::BLANK_W'(stpfp_pkg::BLANK_CYC - 1) // RULE_09
                    : (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_ff    <= '0;
            pwm_on_ff <= 1'b0;
        end
        else if (clr)
        begin
            cnt_ff    <= '0;
            pwm_on_ff <= 1'b0;
        end
        else if (run) // RULE_03
        begin
            cnt_ff    <= nxt_cnt;
            pwm_on_ff <= pwm_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trip only outside the window
    assign trip = run & pwm_on & over_cur & ~blanked; // RULE_08 RULE_09

endmodule

`default_nettype wire

// file: rtl/stpfp_irq.sv
// sticky interrupt status with write-one-to-clear and mask
// assumes one-cycle event pulses and one-cycle write strobes
`default_nettype none

module stpfp_irq
(
    input  wire logic                         clk,
    input  wire logic                         nrst,
    input  wire logic [stpfp_pkg::IRQ_W-1:0]  evt,
    input  wire logic                         stat_wr,
    input  wire logic                         mask_wr,
    input  wire logic [stpfp_pkg::IRQ_W-1:0]  wdata,
    output logic      [stpfp_pkg::IRQ_W-1:0]  stat,
    output logic      [stpfp_pkg::IRQ_W-1:0]  mask,
    output logic                              irq
);

    logic [stpfp_pkg::IRQ_W-1:0] stat_ff;
    logic [stpfp_pkg::IRQ_W-1:0] mask_ff;
    logic                        irq_ff;
    wire  [stpfp_pkg::IRQ_W-1:0] nxt_stat;
    wire  [stpfp_pkg::IRQ_W-1:0] nxt_mask;

    // set wins over clear
    assign nxt_stat = (stat_ff & ~(stat_wr ? wdata : '0)) | evt;
    assign nxt_mask = mask_wr ? wdata : mask_ff;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stat_ff <= '0;
            mask_ff <= stpfp_pkg::IRQ_MASK_RST;
            irq_ff  <= 1'b0;
        end
        else
        begin
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            irq_ff  <= |(nxt_stat & nxt_mask);
        end
    end

    assign stat = stat_ff;
    assign mask = mask_ff;
    assign irq  = irq_ff;

endmodule

`default_nettype wire

// file: tb/stpfp_properties.sv
// port checker of the stepper control block
// assumes bind to stpfp_top, one clock domain
`default_nettype none

module stpfp_properties
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        sys_reset_low,
    input wire logic        enable_in,
    input wire logic        phase_a_in_n,
    input wire logic        phase_a_bar_in_n,
    input wire logic        phase_b_in_n,
    input wire logic        phase_b_bar_in_n,
    input wire logic        pwm_on,
    input wire logic        temp_over_limit,
    input wire logic        drv_a,
    input wire logic        drv_a_bar,
    input wire logic        drv_b,
    input wire logic        drv_b_bar,
    input wire logic        fault_o,
    input wire logic        fault_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    wire logic [3:0] drv = {drv_b_bar, drv_b, drv_a_bar, drv_a};
    wire logic       run = enable_in && sys_reset_low;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////
    a_enable_off: assert property (!enable_in |=> drv == 4'h0)
        else $error("drive on while enable low");
    a_halt_trip: assert property (!enable_in && !fault_oe && sys_reset_low |=> !fault_oe)
        else $error("trip taken while enable low");
    a_no_overlap: assert property (!(drv_a && drv_a_bar) && !(drv_b && drv_b_bar))
        else $error("both phases of a pair on");
    a_drive_follow: assert property (run && $past(run) && $past(nrst) |=> fault_oe ||
        (drv_a == (!$past(phase_a_in_n) && $past(phase_a_bar_in_n)) &&
         drv_b == (!$past(phase_b_in_n) && $past(phase_b_bar_in_n))))
        else $error("drive does not follow phase request");
    a_fault_off: assert property (fault_oe |-> drv == 4'h0)
        else $error("drive on while tripped");
    a_fault_hold: assert property (fault_oe && sys_reset_low |=> fault_oe)
        else $error("trip released without reset");
    a_fault_clear: assert property (!sys_reset_low |=> !fault_oe)
        else $error("fault flag held through reset");
    a_flag_low: assert property (fault_o == 1'b0)
        else $error("fault flag data not low");
    a_heat_trip: assert property (temp_over_limit && run && $past(run) && $past(nrst) |=> fault_oe)
        else $error("overheat not tripped");
    a_blank_hold: assert property ($rose(pwm_on) && !fault_oe && !temp_over_limit |-> ##110 !fault_oe)
        else $error("overcurrent trip inside blanking");

endmodule

`default_nettype wire

// file: tb/stpfp_ctrl_model.sv
// stepping controller model driving phase, enable and reset pins
// assumes one clock; commands from the bench
`default_nettype none

module stpfp_ctrl_model
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        step_en,
    input wire logic        en_req,
    input wire logic        rst_req,
    input wire logic        ovr_en,
    input wire logic [3:0]  ovr_pat,
    output logic            enable_in,
    output logic            sys_reset_low,
    output logic            phase_a_in_n,
    output logic            phase_a_bar_in_n,
    output logic            phase_b_in_n,
    output logic            phase_b_bar_in_n
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] idx_ff;
    logic [3:0] cnt_ff;
    logic [3:0] per_ff;
    wire logic [3:0] pat = (idx_ff == 2'h0) ? 4'h9 : (idx_ff == 2'h1) ? 4'h5 : (idx_ff == 2'h2) ? 4'h6 : 4'ha;
    wire logic       stp = cnt_ff >= per_ff;

    // pins active low, order {b_bar, b, a_bar, a}
    assign {phase_b_bar_in_n, phase_b_in_n, phase_a_bar_in_n, phase_a_in_n} = ovr_en ? ~ovr_pat : ~pat;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            enable_in <= 1'b0;
            sys_reset_low <= 1'b1;
            idx_ff <= 2'h0;
            cnt_ff <= 4'h0;
            per_ff <= 4'hf;
        end
        else
        begin
            enable_in <= en_req;
            sys_reset_low <= !rst_req;
            cnt_ff <= stp ? 4'h0 : cnt_ff + 4'h1;
            if (stp && (step_en || per_ff < 4'hf))
            begin
                idx_ff <= idx_ff + 2'h1;
                per_ff <= step_en ? 4'h2 : per_ff + 4'h1;
            end
        end
    end

endmodule

`default_nettype wire

// file: tb/stpfp_top_test.sv
// self-checking bench of the stepper control block
// assumes the controller model and the port checker beside it
`default_nettype none

module stpfp_top_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, nrst, pwm_on, cur, temp, reg_wr, reg_rd;
    logic step_en, en_req, rst_req, ovr_en;
    logic [3:0] ovr_pat;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, seed;
    int fail_count, checked;
    wire logic [31:0] reg_rdata;
    wire logic en, srl, pa, pab, pb, pbb, da, dab, db, dbb, f_o, f_oe, irq;
    wire logic [3:0] drv = {dbb, db, dab, da};
    wire logic [3:0] pins = {pbb, pb, pab, pa};

    stpfp_ctrl_model stpfp_ctrl_model_inst (.clk(clk), .nrst(nrst), .step_en(step_en), .en_req(en_req),
        .rst_req(rst_req), .ovr_en(ovr_en), .ovr_pat(ovr_pat), .enable_in(en), .sys_reset_low(srl),
        .phase_a_in_n(pa), .phase_a_bar_in_n(pab), .phase_b_in_n(pb), .phase_b_bar_in_n(pbb));
    stpfp_top stpfp_top_inst (.clk(clk), .nrst(nrst), .sys_reset_low(srl), .enable_in(en), .phase_a_in_n(pa),
        .phase_a_bar_in_n(pab), .phase_b_in_n(pb), .phase_b_bar_in_n(pbb), .pwm_on(pwm_on),
        .cur_over_limit(cur), .temp_over_limit(temp), .drv_a(da), .drv_a_bar(dab), .drv_b(db), .drv_b_bar(dbb),
        .fault_o(f_o), .fault_oe(f_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

    always #25 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] expd(input logic [3:0] pn);
        logic [3:0] r;
        r = ~pn;
        if (r[0] && r[1]) r[1:0] = 2'h0;
        if (r[2] && r[3]) r[3:2] = 2'h0;
        return r;
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(20000);
        fail_count++;
        give_verdict();
    end

    initial
    begin
        logic [31:0] d;
        logic [3:0] p;
        int k;
        {clk, nrst, pwm_on, cur, temp, reg_wr, reg_rd, step_en, en_req, rst_req, ovr_en} = '0;
        {ovr_pat, reg_addr, reg_wdata} = '0;
        seed = 32'h00015abd;
        fail_count = 0;
        checked = 0;
        tick(10);
        nrst <= 1'b1;
        rd(stpfp_pkg::OFS_CTRL, d);
        chk(d, 32'h1);
        rd(stpfp_pkg::OFS_IRQ_MASK, d);
        chk(d, 32'h0);
        seed = lfsr(seed);
        wr(8'h10, seed);
        rd(8'h10, d);
        chk(d, 32'h0);
        en_req <= 1'b1;
        ovr_en <= 1'b1;
        for (int i = 0; i < 24; i++)
        begin
            seed = lfsr(seed);
            ovr_pat <= (i < 16) ? 4'(i) : seed[3:0];
            tick(4);
            chk(32'(drv), 32'(expd(pins)));
        end
        ovr_en <= 1'b0;
        step_en <= 1'b1;
        @(negedge clk);
        p = pins;
        repeat (60)
        begin
            @(negedge clk);
            chk(32'(drv), 32'(expd(p)));
            p = pins;
        end
        step_en <= 1'b0;
        tick(200);
        $display("test 1 done");
        ovr_en <= 1'b1;
        ovr_pat <= 4'h5;
        tick(4);
        p = drv;
        en_req <= 1'b0;
        tick(1);
        ovr_pat <= 4'ha;
        temp <= 1'b1;
        tick(5);
        chk(32'(drv), 32'h0);
        rd(stpfp_pkg::OFS_STATUS, d);
        chk(32'(d[stpfp_pkg::ST_PH_LSB +: 4]), 32'(p));
        temp <= 1'b0;
        ovr_pat <= 4'h5;
        en_req <= 1'b1;
        tick(3);
        @(negedge clk);
        chk(32'(drv), 32'(p));
        chk(32'(f_oe), 32'h0);
        $display("test 2 done");
        wr(stpfp_pkg::OFS_IRQ_MASK, 32'h3);
        @(posedge clk);
        temp <= 1'b1;
        tick(1);
        temp <= 1'b0;
        tick(3);
        chk(32'(f_oe), 32'h1);
        chk(32'(drv), 32'h0);
        chk(32'(irq), 32'h1);
        rd(stpfp_pkg::OFS_IRQ_STAT, d);
        chk(d, 32'h2);
        wr(stpfp_pkg::OFS_IRQ_STAT, 32'h2);
        tick(2);
        chk(32'(irq), 32'h0);
        rd(stpfp_pkg::OFS_STATUS, d);
        chk(32'(d[1:0]), 32'h2);
        rst_req <= 1'b1;
        tick(3);
        rd(stpfp_pkg::OFS_STATUS, d);
        chk(32'(d[stpfp_pkg::ST_PH_LSB +: 4]), 32'(stpfp_pkg::PHASE_INIT));
        chk(32'(f_oe), 32'h0);
        rst_req <= 1'b0;
        tick(3);
        $display("test 3 done");
        wr(stpfp_pkg::OFS_IRQ_MASK, 32'h0);
        @(posedge clk);
        pwm_on <= 1'b1;
        cur <= 1'b1;
        tick(100);
        chk(32'(f_oe), 32'h0);
        k = 0;
        while (f_oe !== 1'b1 && k < 40)
        begin
            @(negedge clk);
            k++;
        end
        chk(32'(k), 32'(stpfp_pkg::BLANK_CYC - 98));
        cur <= 1'b0;
        pwm_on <= 1'b0;
        rd(stpfp_pkg::OFS_IRQ_STAT, d);
        chk(d, 32'h1);
        chk(32'(irq), 32'h0);
        tick(2);
        nrst <= 1'b0;
        tick(2);
        nrst <= 1'b1;
        tick(3);
        chk(32'(f_oe), 32'h0);
        $display("test 4 done");
        give_verdict();
    end

endmodule

bind stpfp_top stpfp_properties stpfp_properties_inst (.clk(clk), .nrst(nrst), .sys_reset_low(sys_reset_low),
    .enable_in(enable_in), .phase_a_in_n(phase_a_in_n), .phase_a_bar_in_n(phase_a_bar_in_n),
    .phase_b_in_n(phase_b_in_n), .phase_b_bar_in_n(phase_b_bar_in_n), .pwm_on(pwm_on),
    .temp_over_limit(temp_over_limit), .drv_a(drv_a), .drv_a_bar(drv_a_bar), .drv_b(drv_b),
    .drv_b_bar(drv_b_bar), .fault_o(fault_o), .fault_oe(fault_oe));

`default_nettype wire
